// File: pxr_defs.svh
// Offsets, field positions and reset values for the paged external RAM
`ifndef PXR_DEFS_SVH
`define PXR_DEFS_SVH

`define PXR_RAM_BYTES        512
`define PXR_RAM_AW           9
`define PXR_PAGE_CTRL_OFS    8'hAA
`define PXR_PAGE_CTRL_RST    8'h00
`define PXR_PAGE_SEL_BIT     0
`define PXR_MOVE_CTRL_OFS    8'hAB
`define PXR_MOVE_CTRL_RST    8'h00
`define PXR_REDIRECT_BIT     0
`define PXR_STATUS_OFS       8'hAC

`endif

// File: pxr_pkg.sv
// Types shared by the paged external RAM block
package pxr_pkg;

   typedef enum logic [0:0] {
      PXR_MODE_PTR16 = 1'b0,
      PXR_MODE_IND8  = 1'b1
   } pxr_mode_type;

   typedef struct packed {
      logic         rd;
      logic         wr;
      pxr_mode_type mode;
      logic [15:0]  addr;
      logic [7:0]   wdata;
   } pxr_req_type;

   typedef struct packed {
      logic        wr;
      logic [8:0]  addr;
      logic [7:0]  wdata;
   } pxr_ram_cmd_type;

endpackage : pxr_pkg

// File: pxr_addr_map.sv
// Address former for external-move accesses
`timescale 1ns/10ps
`default_nettype none
`include "pxr_defs.svh"

module pxr_addr_map
   import pxr_pkg::*;
(
   input  wire pxr_mode_type mode,
   input  wire logic [15:0]  addr_in,
   input  wire logic         page_sel,
   output var  logic [15:0]  full_addr,
   output var  logic [8:0]   ram_addr
);

   always_comb begin
      // page is only 0 or 1
      if (mode == PXR_MODE_IND8) begin
         full_addr = {7'h00, page_sel, addr_in[7:0]};
      end else begin
         full_addr = addr_in;
      end
      ram_addr = full_addr[`PXR_RAM_AW-1:0];
   end

endmodule : pxr_addr_map
`default_nettype wire

// File: pxr_ram.sv
// Byte-wide single-port RAM with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "pxr_defs.svh"

module pxr_ram
   import pxr_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            en,
   input  wire pxr_ram_cmd_type cmd,
   output var  logic [7:0]      rdata
);

   logic [7:0] mem_reg [0:`PXR_RAM_BYTES-1];

   always_ff @(posedge clk) begin
      if (en && cmd.wr) begin
         mem_reg[cmd.addr] <= cmd.wdata;
      end
   end

   // Contents are not reset, as in a real RAM
   always_ff @(posedge clk) begin
      if (en && !cmd.wr) begin
         rdata <= mem_reg[cmd.addr];
      end
   end

endmodule : pxr_ram
`default_nettype wire

// File: pxr_top.sv
// Paged external data RAM with page and move-control registers
//
// Overview of operation
// - 512 bytes RAM in external data space
// - 8-bit operand: page supplies high byte
// - 16-bit pointer: only low nine bits decoded
// - RAM repeats every 0x200 across 64k
// - Moves hit RAM unless redirect enabled
// - Page select bit picks 256-byte half
`timescale 1ns/10ps
`default_nettype none
`include "pxr_defs.svh"

module pxr_top
   import pxr_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output var  logic [7:0]  REG_RDATA,
   input  wire logic        MOVE_RD,
   input  wire logic        MOVE_WR,
   input  wire logic        MOVE_IND8,
   input  wire logic [15:0] MOVE_ADDR,
   input  wire logic [7:0]  MOVE_WDATA,
   output var  logic [7:0]  MOVE_RDATA,
   output var  logic        MOVE_RVALID,
   output var  logic        REDIR_RD,
   output var  logic        REDIR_WR,
   output var  logic [15:0] REDIR_ADDR,
   output var  logic [7:0]  REDIR_WDATA
);

   pxr_req_type     req;
   pxr_ram_cmd_type ram_cmd;
   logic [7:0]      page_ctrl_reg;
   logic [7:0]      move_ctrl_reg;
   logic [15:0]     full_addr;
   logic [8:0]      ram_addr;
   logic [7:0]      ram_rdata;
   logic            ram_en;
   logic            redirect;
   logic            ram_rd_pend_reg;
   logic            redir_wr_cnt_reg;

   always_comb begin
      req.rd    = MOVE_RD;
      req.wr    = MOVE_WR;
      req.mode  = MOVE_IND8 ? PXR_MODE_IND8 : PXR_MODE_PTR16;
      req.addr  = MOVE_ADDR;
      req.wdata = MOVE_WDATA;
   end

   assign redirect = move_ctrl_reg[`PXR_REDIRECT_BIT];

   pxr_addr_map pxr_addr_map_inst (
      .mode      (req.mode),
      .addr_in   (req.addr),
      .page_sel  (page_ctrl_reg[`PXR_PAGE_SEL_BIT]),
      .full_addr (full_addr),
      .ram_addr  (ram_addr)
   );

   assign ram_en = (req.rd || req.wr) && !redirect;

   always_comb begin
      ram_cmd.wr    = req.wr;
      ram_cmd.addr  = ram_addr;
      ram_cmd.wdata = req.wdata;
   end

   pxr_ram pxr_ram_inst (
      .clk   (CLK),
      .en    (ram_en),
      .cmd   (ram_cmd),
      .rdata (ram_rdata)
   );

   // Only the page bit is stored; upper bits read zero
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         page_ctrl_reg <= `PXR_PAGE_CTRL_RST;
      end else if (REG_WR && REG_ADDR == `PXR_PAGE_CTRL_OFS) begin
         page_ctrl_reg <= {7'h00, REG_WDATA[`PXR_PAGE_SEL_BIT]};
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         move_ctrl_reg <= `PXR_MOVE_CTRL_RST;
      end else if (REG_WR && REG_ADDR == `PXR_MOVE_CTRL_OFS) begin
         move_ctrl_reg <= {7'h00, REG_WDATA[`PXR_REDIRECT_BIT]};
      end
   end

   // Status: redirect enable and parity of redirected writes
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         redir_wr_cnt_reg <= 1'b0;
      end else if (req.wr && redirect) begin
         redir_wr_cnt_reg <= !redir_wr_cnt_reg;
      end
   end

   // Unmapped offsets read as zero
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `PXR_PAGE_CTRL_OFS: REG_RDATA <= page_ctrl_reg;
            `PXR_MOVE_CTRL_OFS: REG_RDATA <= move_ctrl_reg;
            `PXR_STATUS_OFS:    REG_RDATA <= {6'h00, redir_wr_cnt_reg, redirect};
            default:            REG_RDATA <= 8'h00;
         endcase
      end else begin
         REG_RDATA <= 8'h00;
      end
   end

   // Read data one cycle after the strobe
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ram_rd_pend_reg <= 1'b0;
      end else begin
         ram_rd_pend_reg <= req.rd && !req.wr && !redirect;
      end
   end

   assign MOVE_RVALID = ram_rd_pend_reg;
   assign MOVE_RDATA  = ram_rd_pend_reg ? ram_rdata : 8'h00;

   // Redirected moves leave through registered outputs
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         REDIR_RD    <= 1'b0;
         REDIR_WR    <= 1'b0;
         REDIR_ADDR  <= 16'h0000;
         REDIR_WDATA <= 8'h00;
      end else begin
         REDIR_RD    <= req.rd && redirect;
         REDIR_WR    <= req.wr && redirect;
         REDIR_ADDR  <= full_addr;
         REDIR_WDATA <= req.wdata;
      end
   end

endmodule : pxr_top
`default_nettype wire

// File: pxr_checker.sv
// Port assertions for the paged external RAM
`timescale 1ns/10ps
`default_nettype none
module pxr_checker (
   input wire logic        CLK,
   input wire logic        SYS_RST,
   input wire logic        MOVE_RD,
   input wire logic        MOVE_WR,
   input wire logic        MOVE_IND8,
   input wire logic [15:0] MOVE_ADDR,
   input wire logic        MOVE_RVALID,
   input wire logic        REDIR_RD,
   input wire logic        REDIR_WR,
   input wire logic [15:0] REDIR_ADDR,
   input wire logic [7:0]  REG_RDATA
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   rvalid_src_a: assert property (MOVE_RVALID |-> $past(MOVE_RD))
      else $error("rvalid without read");
   rd_answer_a: assert property (MOVE_RD |=> MOVE_RVALID || REDIR_RD)
      else $error("read not answered");
   one_target_a: assert property ($onehot0({MOVE_RVALID, REDIR_RD, REDIR_WR}))
      else $error("move hit two targets");
   redir_src_a: assert property (REDIR_WR |-> $past(MOVE_WR))
      else $error("redirect without write");
   ptr_addr_a: assert property ((MOVE_RD || MOVE_WR) && !MOVE_IND8 |=>
      !(REDIR_RD || REDIR_WR) || REDIR_ADDR == $past(MOVE_ADDR)) else $error("pointer address");
   page_addr_a: assert property ((MOVE_RD || MOVE_WR) && MOVE_IND8 |=>
      !(REDIR_RD || REDIR_WR) || REDIR_ADDR[15:9] == 7'h00) else $error("page high bits");
   reg_unused_a: assert property (REG_RDATA[7:2] == 6'h00)
      else $error("unused bits set");
endmodule : pxr_checker
bind pxr_top pxr_checker pxr_checker_inst (.*);
`default_nettype wire

// File: pxr_core_model.sv
// Processor core model issuing external moves
`timescale 1ns/10ps
`default_nettype none
module pxr_core_model (
   input  wire logic        clk,
   output var  logic        move_rd,
   output var  logic        move_wr,
   output var  logic        move_ind8,
   output var  logic [15:0] move_addr,
   output var  logic [7:0]  move_wdata,
   input  wire logic [7:0]  move_rdata
);
   initial begin
      move_rd = 1'b0;
      move_wr = 1'b0;
      move_ind8 = 1'b0;
      move_addr = 16'h0000;
      move_wdata = 8'h00;
   end
   task automatic mv(input logic w, input logic i, input logic [15:0] a,
                     input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      move_wr <= w;
      move_rd <= !w;
      move_ind8 <= i;
      move_addr <= a;
      move_wdata <= d;
      @(posedge clk);
      move_wr <= 1'b0;
      move_rd <= 1'b0;
      // Released lines flip so stale values never look valid
      move_addr <= ~a;
      move_wdata <= ~d;
      @(posedge clk);
      q = move_rdata;
   endtask : mv
endmodule : pxr_core_model
`default_nettype wire

// File: test_pxr_top.sv
// Self-checking bench for the paged external RAM
`timescale 1ns/10ps
`default_nettype none
module test_pxr_top;
   logic        clk, rst, rwr, rrd, mrd, mwr, mi8, mrv, rdr, rdw;
   logic [7:0]  ra, rwd, rrdata, mwd, mrdata, q, rdwd;
   logic [15:0] ma, rda;
   int          errors = 0;
   int          check_count = 0;
   pxr_top pxr_top_inst (.CLK(clk), .SYS_RST(rst), .REG_ADDR(ra), .REG_WDATA(rwd),
      .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rrdata), .MOVE_RD(mrd), .MOVE_WR(mwr),
      .MOVE_IND8(mi8), .MOVE_ADDR(ma), .MOVE_WDATA(mwd), .MOVE_RDATA(mrdata),
      .MOVE_RVALID(mrv), .REDIR_RD(rdr), .REDIR_WR(rdw), .REDIR_ADDR(rda),
      .REDIR_WDATA(rdwd));
   pxr_core_model core (.clk(clk), .move_rd(mrd), .move_wr(mwr), .move_ind8(mi8),
      .move_addr(ma), .move_wdata(mwd), .move_rdata(mrdata));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      rwr <= w;
      rrd <= !w;
      ra <= a;
      rwd <= d;
      @(posedge clk);
      rwr <= 1'b0;
      rrd <= 1'b0;
      @(posedge clk);
      q = rrdata;
   endtask : rw
   task automatic print_verdict();
      if (errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   task automatic t_regs();
      rw(1'b0, 8'hAA, 8'h00);
      chk(q, 8'h00);
      rw(1'b0, 8'hAB, 8'h00);
      chk(q, 8'h00);
      rw(1'b0, 8'h00, 8'h00);
      chk(q, 8'h00);
      rw(1'b1, 8'hAA, 8'hFF);
      rw(1'b0, 8'hAA, 8'h00);
      chk(q, 8'h01);
   endtask : t_regs
   task automatic t_alias();
      core.mv(1'b1, 1'b0, 16'h0203, 8'h5A, q);
      core.mv(1'b0, 1'b0, 16'hFE03, 8'h00, q);
      chk(q, 8'h5A);
      // Checked in the edge step that ends the read cycle
      chk({7'h00, mrv}, 8'h01);
      core.mv(1'b0, 1'b0, 16'h0003, 8'h00, q);
      chk(q, 8'h5A);
   endtask : t_alias
   task automatic t_page();
      core.mv(1'b1, 1'b1, 16'hFF03, 8'hA5, q);
      core.mv(1'b0, 1'b0, 16'h0103, 8'h00, q);
      chk(q, 8'hA5);
      rw(1'b1, 8'hAA, 8'h00);
      core.mv(1'b0, 1'b1, 16'h0003, 8'h00, q);
      chk(q, 8'h5A);
   endtask : t_page
   task automatic t_redir();
      rw(1'b1, 8'hAB, 8'h01);
      core.mv(1'b1, 1'b0, 16'h0203, 8'h77, q);
      chk({6'h00, rdr, rdw}, 8'h01);
      chk(rda[15:8], 8'h02);
      chk(rda[7:0], 8'h03);
      chk(rdwd, 8'h77);
      core.mv(1'b0, 1'b1, 16'hFF03, 8'h00, q);
      chk(q, 8'h00);
      chk({6'h00, rdr, rdw}, 8'h02);
      chk(rda[15:8], 8'h00);
      chk(rda[7:0], 8'h03);
      rw(1'b0, 8'hAC, 8'h00);
      chk(q, 8'h03);
      rw(1'b1, 8'hAB, 8'h00);
      core.mv(1'b0, 1'b0, 16'h0403, 8'h00, q);
      chk(q, 8'h5A);
   endtask : t_redir
   task automatic t_reset();
      rw(1'b1, 8'hAA, 8'h01);
      rw(1'b1, 8'hAB, 8'h01);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rw(1'b0, 8'hAA, 8'h00);
      chk(q, 8'h00);
      rw(1'b0, 8'hAB, 8'h00);
      chk(q, 8'h00);
      rw(1'b0, 8'hAC, 8'h00);
      chk(q, 8'h00);
   endtask : t_reset
   initial begin
      rst = 1'b1;
      rwr = 1'b0;
      rrd = 1'b0;
      ra = 8'h00;
      rwd = 8'h00;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_alias();
      t_page();
      t_redir();
      t_reset();
      print_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      print_verdict();
   end
endmodule : test_pxr_top
`default_nettype wire
